/* include/rftxg_pkg.sv */
// Purpose: shared constants and types for the transmit guard and power control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
`default_nettype none
package rftxg_pkg;
    localparam logic [7:0] TX_CLOCK_CONTROL_OFS = 8'h00;
    localparam logic [7:0] TX_CONTROL_OFS = 8'h04;
    localparam logic [7:0] GUARD_CFG_OFS = 8'h08;
    localparam logic [7:0] SEQ_CTRL_OFS = 8'h0C;
    localparam logic [7:0] DRIVE_CFG_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;

    // clock mode codes
    localparam logic [2:0] CLK_HIGH_Z = 3'h0;
    localparam logic [2:0] CLK_FORCE_LOW = 3'h1;
    localparam logic [2:0] CLK_FORCE_HIGH = 3'h2;
    localparam logic [2:0] CLK_LOW_PULL = 3'h5;
    localparam logic [2:0] CLK_HIGH_PUSH = 3'h6;
    localparam logic [2:0] CLK_PUSH_PULL = 3'h7;

    localparam logic [4:0] CARRIER_FULL = 5'h00;
    localparam logic [4:0] CARRIER_NONE = 5'h1F;
    localparam logic [3:0] GEAR_MAX = 4'hE;
    localparam logic [7:0] GUARD_OFF = 8'h00;

    // guard time unit in ns and in clock cycles
    localparam int GUARD_UNIT_NS = 1000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int GUARD_UNIT_CYC = GUARD_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] GUARD_UNIT_CYC_W = 8'(GUARD_UNIT_CYC);
    localparam logic [7:0] ONE8 = 8'h01;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [3:0] ONE4 = 4'h1;

    // field positions
    localparam int CM_LSB = 0;
    localparam int SCM_LSB = 4;
    localparam int RC_LSB = 0;
    localparam int SRC_LSB = 8;
    localparam int SYNC_BIT = 8;
    localparam int RFON_BIT = 9;
    localparam int MULTI_BIT = 10;
    localparam int GO_BIT = 0;
    localparam int GMIN_LSB = 0;
    localparam int GMAX_LSB = 8;
    localparam int GCNT_LSB = 16;
    localparam int IVL_LSB = 24;

    typedef struct packed {
        logic [2:0] clock_mode;
        logic [4:0] carrier_level;
        logic [3:0] gear;
    } rftxg_drive_t;

    typedef enum logic [3:0] {
        RFTXG_IDLE = 4'h1,
        RFTXG_GUARD = 4'h2,
        RFTXG_WAIT_GRID = 4'h4,
        RFTXG_SEND = 4'h8
    } rftxg_state_t;
endpackage
`default_nettype wire

/* hdl/rftxg_core.sv */
// Purpose: transmit guard timer, modulation drive select and load-adaptive gear stepping
// Assumes: all inputs synchronous to pclk
// Notes: with the TX clock mode field at push-pull and no overshoot, the regulation loop trims the carrier code by the measured modulation error
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module rftxg_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receiver and field events
    input wire logic rx_end,
    input wire logic rx_emd_restart,
    input wire logic field_on,
    input wire logic bit_grid_tick,
    input wire logic send_cmd,
    input wire logic tx_done,
    // shaping and modulation
    input wire logic shaping_active,
    input wire logic overshoot_active,
    input wire logic [4:0] mod_error_trim,
    input wire logic [7:0] gain_value,
    // drive outputs
    output logic tx_start,
    output logic tx_busy,
    output rftxg_pkg::rftxg_drive_t drive
);
    logic [7:0] tx_clock_control_reg_q;
    logic [15:0] tx_control_reg_q;
    logic [15:0] guard_cfg_q;
    logic [31:0] drive_cfg_q;
    logic go_q;
    logic [7:0] guard_cnt_q;
    logic [7:0] unit_cnt_q;
    logic [15:0] meas_cnt_q;
    logic [3:0] gear_q;
    logic [4:0] carrier_q;
    logic [2:0] clock_mode_q;
    rftxg_pkg::rftxg_state_t state_q;
    rftxg_pkg::rftxg_state_t state_d;
    logic wr_en;
    logic rd_en;
    logic guard_start;
    logic guard_done;
    logic meas_tick;
    logic [2:0] tx_clock_mode_field;
    logic [2:0] shaping_period_clock_mode;
    logic [4:0] carrier_field;
    logic [4:0] shaping_period_carrier_level;
    logic bit_grid_sync_en;
    logic guard_on_field_up_en;
    logic multi_rx_en;
    logic [7:0] guard_setting;
    logic [3:0] gear_min;
    logic [3:0] gear_max;
    logic [7:0] gain_hi;
    logic [7:0] gain_lo;
    logic [7:0] measure_interval_setting;

    // saturating add of a trim to a five-bit carrier code
    function automatic logic [4:0] sat_add(input logic [4:0] a, input logic [4:0] b);
        logic [5:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[5] ? rftxg_pkg::CARRIER_NONE : s[4:0];
    endfunction

    assign wr_en = psel && penable && pwrite && clk_en;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign tx_clock_mode_field = tx_clock_control_reg_q[rftxg_pkg::CM_LSB +: 3];
    assign shaping_period_clock_mode = tx_clock_control_reg_q[rftxg_pkg::SCM_LSB +: 3];
    assign carrier_field = tx_control_reg_q[rftxg_pkg::RC_LSB +: 5];
    assign shaping_period_carrier_level = tx_control_reg_q[rftxg_pkg::SRC_LSB +: 5];
    assign guard_setting = guard_cfg_q[7:0];
    assign bit_grid_sync_en = guard_cfg_q[rftxg_pkg::SYNC_BIT];
    assign guard_on_field_up_en = guard_cfg_q[rftxg_pkg::RFON_BIT];
    assign multi_rx_en = guard_cfg_q[rftxg_pkg::MULTI_BIT];
    assign gear_min = drive_cfg_q[rftxg_pkg::GMIN_LSB +: 4];
    assign gear_max = drive_cfg_q[rftxg_pkg::GMAX_LSB +: 4];
    assign gain_lo = drive_cfg_q[rftxg_pkg::GCNT_LSB +: 8];
    assign gain_hi = {drive_cfg_q[rftxg_pkg::GCNT_LSB + 4 +: 4], 4'hF};
    assign measure_interval_setting = drive_cfg_q[rftxg_pkg::IVL_LSB +: 8];

    // ==========================================
    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_clock_control_reg_q <= 8'h00;
            tx_control_reg_q <= 16'h0000;
            guard_cfg_q <= 16'h0000;
            drive_cfg_q <= 32'h0000_0000;
        end else if (wr_en) begin
            if (paddr == rftxg_pkg::TX_CLOCK_CONTROL_OFS) begin
                tx_clock_control_reg_q <= pwdata[7:0];
            end else if (paddr == rftxg_pkg::TX_CONTROL_OFS) begin
                tx_control_reg_q <= pwdata[15:0];
            end else if (paddr == rftxg_pkg::GUARD_CFG_OFS) begin
                guard_cfg_q <= pwdata[15:0];
            end else if (paddr == rftxg_pkg::DRIVE_CFG_OFS) begin
                drive_cfg_q <= pwdata;
            end
        end
    end

    // ==========================================
    // register reads, data registered in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en && rd_en) begin
            pslverr <= 1'b0;
            if (paddr == rftxg_pkg::TX_CLOCK_CONTROL_OFS) begin
                prdata <= {24'h000000, tx_clock_control_reg_q};
            end else if (paddr == rftxg_pkg::TX_CONTROL_OFS) begin
                prdata <= {16'h0000, tx_control_reg_q};
            end else if (paddr == rftxg_pkg::GUARD_CFG_OFS) begin
                prdata <= {16'h0000, guard_cfg_q};
            end else if (paddr == rftxg_pkg::SEQ_CTRL_OFS) begin
                prdata <= {31'h00000000, go_q};
            end else if (paddr == rftxg_pkg::DRIVE_CFG_OFS) begin
                prdata <= drive_cfg_q;
            end else if (paddr == rftxg_pkg::STATUS_OFS) begin
                prdata <= {8'h00, guard_cnt_q, 4'h0, state_q, 4'h0, gear_q};
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b1;
            end
        end else if (clk_en && psel && !penable) begin
            prdata <= 32'h0000_0000;
            pslverr <= !(paddr <= rftxg_pkg::STATUS_OFS && paddr[1:0] == 2'b00);
        end
    end

    // ==========================================
    // transmit go flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_q <= 1'b0;
        end else if (clk_en) begin
            if ((wr_en && paddr == rftxg_pkg::SEQ_CTRL_OFS && pwdata[rftxg_pkg::GO_BIT])
                    || send_cmd) begin
                go_q <= 1'b1;
            end else if (tx_start) begin
                go_q <= 1'b0;
            end
        end
    end
    go_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && send_cmd |=> go_q)
        else $error("go flag not set by send command");

    // ==========================================
    // guard timer
    // start at reception end
    // no start on restart or multi
    assign guard_start = (rx_end && !rx_emd_restart && !multi_rx_en)
        || (field_on && guard_on_field_up_en);
    assign guard_done = (guard_cnt_q == 8'h00) || (guard_setting == rftxg_pkg::GUARD_OFF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard_cnt_q <= 8'h00;
            unit_cnt_q <= 8'h00;
        end else if (clk_en) begin
            if (guard_start && guard_setting != rftxg_pkg::GUARD_OFF) begin
                guard_cnt_q <= guard_setting;
                unit_cnt_q <= rftxg_pkg::GUARD_UNIT_CYC_W - rftxg_pkg::ONE8;
            end else if (guard_cnt_q != 8'h00) begin
                if (unit_cnt_q == 8'h00) begin
                    unit_cnt_q <= rftxg_pkg::GUARD_UNIT_CYC_W - rftxg_pkg::ONE8;
                    guard_cnt_q <= guard_cnt_q - rftxg_pkg::ONE8;
                end else begin
                    unit_cnt_q <= unit_cnt_q - rftxg_pkg::ONE8;
                end
            end
        end
    end
    guard_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && guard_start && guard_setting != rftxg_pkg::GUARD_OFF
        |=> guard_cnt_q == $past(guard_setting))
        else $error("guard count not loaded at start");
    restart_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && rx_end && (rx_emd_restart || multi_rx_en) && !field_on && guard_cnt_q == 8'h00
        |=> guard_cnt_q == 8'h00) else $error("guard started on restart");

    // ==========================================
    // transmit sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            rftxg_pkg::RFTXG_IDLE: begin
                if (guard_start && guard_setting != rftxg_pkg::GUARD_OFF) begin
                    state_d = rftxg_pkg::RFTXG_GUARD;
                end else if (go_q && guard_done) begin
                    state_d = rftxg_pkg::RFTXG_SEND;
                end
            end
            rftxg_pkg::RFTXG_GUARD: begin
                if (guard_done) begin
                    if (go_q) begin
                        state_d = rftxg_pkg::RFTXG_SEND;
                    end else if (bit_grid_sync_en) begin
                        state_d = rftxg_pkg::RFTXG_WAIT_GRID;
                    end else begin
                        state_d = rftxg_pkg::RFTXG_IDLE;
                    end
                end
            end
            rftxg_pkg::RFTXG_WAIT_GRID: begin
                if (go_q && bit_grid_tick && guard_done) begin
                    state_d = rftxg_pkg::RFTXG_SEND;
                end
            end
            rftxg_pkg::RFTXG_SEND: begin
                if (tx_done) begin
                    state_d = rftxg_pkg::RFTXG_IDLE;
                end
            end
            default: state_d = rftxg_pkg::RFTXG_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= rftxg_pkg::RFTXG_IDLE;
            tx_start <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            tx_start <= (state_d == rftxg_pkg::RFTXG_SEND) && (state_q != rftxg_pkg::RFTXG_SEND);
        end
    end
    assign tx_busy = (state_q == rftxg_pkg::RFTXG_SEND);
    guard_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !guard_done |=> !tx_start)
        else $error("transmission started inside guard period");
    expiry_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == rftxg_pkg::RFTXG_GUARD && guard_done && go_q |=> tx_start)
        else $error("no start at guard expiry");

    // ==========================================
    // drive selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_mode_q <= rftxg_pkg::CLK_HIGH_Z;
            carrier_q <= rftxg_pkg::CARRIER_FULL;
        end else if (clk_en) begin
            clock_mode_q <= shaping_active ? shaping_period_clock_mode : tx_clock_mode_field;
            if (overshoot_active) begin
                carrier_q <= shaping_period_carrier_level;
            end else if (tx_clock_mode_field == rftxg_pkg::CLK_PUSH_PULL) begin
                carrier_q <= sat_add(carrier_field, mod_error_trim);
            end else begin
                carrier_q <= carrier_field;
            end
        end
    end
    shaping_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && shaping_active |=> drive.clock_mode == $past(shaping_period_clock_mode))
        else $error("shaping clock mode not applied");

    // ==========================================
    // load-adaptive drive gear
    // sample on interval
    assign meas_tick = (meas_cnt_q == 16'h0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_cnt_q <= 16'h0000;
            gear_q <= 4'h0;
        end else if (clk_en) begin
            meas_cnt_q <= meas_tick ? {measure_interval_setting, 8'hFF}
                : meas_cnt_q - rftxg_pkg::ONE16;
            if (meas_tick) begin
                // max steps down, min steps up
                if (gain_value > gain_hi && gear_q > gear_min) begin
                    gear_q <= gear_q - rftxg_pkg::ONE4;
                end else if (gain_value < gain_lo && gear_q < gear_max
                        && gear_q < rftxg_pkg::GEAR_MAX) begin
                    gear_q <= gear_q + rftxg_pkg::ONE4;
                end
            end
        end
    end

    assign drive = '{clock_mode: clock_mode_q, carrier_level: carrier_q, gear: gear_q};
endmodule
`default_nettype wire

/* dv/rftxg_ant_model.sv */
// Purpose: antenna driver stand-in that answers each transmission start with a done pulse
// Assumes: tx_start is a one-cycle pulse on pclk
// Notes: slow selects a long transmission, otherwise done follows after a few cycles
`timescale 1ns/1ns
`default_nettype none
module rftxg_ant_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // transmission handshake
    input wire logic slow,
    input wire logic tx_start,
    output logic tx_done
);
    logic [5:0] left_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= 6'h00;
            tx_done <= 1'h0;
        end else begin
            tx_done <= (left_q == 6'h01);
            if (tx_start) begin
                left_q <= slow ? 6'h28 : 6'h03;
            end else if (left_q != 6'h00) begin
                left_q <= left_q - 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* dv/rftxg_core_tb.sv */
// Purpose: self-checking bench for the transmit guard and power control block
// Assumes: zero-wait APB slave, 40 ns clock
// Notes: drive settings run from a table, guard and gear cases follow by hand
`timescale 1ns/1ns
`default_nettype none
module rftxg_core_tb;
    typedef struct {
        logic [2:0] cm, scm;
        logic [4:0] car, scar, trim;
        logic sh, ov;
        logic [2:0] ecm;
        logic [4:0] ecar;
    } rftxg_row_t;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, emd = 1'h0, sh = 1'h0, ov = 1'h0;
    logic slow = 1'h0, en = 1'h1, err;
    logic [7:0] paddr = 8'h00, gain = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, tx_start, tx_busy, tx_done;
    logic [4:0] trim = 5'h00;
    logic [3:0] ev = 4'h0;
    rftxg_pkg::rftxg_drive_t drive;
    int num_errors = 0, n_tests = 0, cyc = 0, t_ev = 0, t_start = 0, n_start = 0, dt, s;
    rftxg_row_t rows [11] = '{
        '{3'h0, 3'h7, 5'h05, 5'h00, 5'h00, 1'h0, 1'h0, 3'h0, 5'h05},
        '{3'h1, 3'h0, 5'h05, 5'h00, 5'h00, 1'h0, 1'h0, 3'h1, 5'h05},
        '{3'h2, 3'h0, 5'h05, 5'h00, 5'h00, 1'h0, 1'h0, 3'h2, 5'h05},
        '{3'h5, 3'h0, 5'h05, 5'h00, 5'h00, 1'h0, 1'h0, 3'h5, 5'h05},
        '{3'h6, 3'h0, 5'h05, 5'h00, 5'h00, 1'h0, 1'h0, 3'h6, 5'h05},
        '{3'h7, 3'h0, 5'h00, 5'h00, 5'h00, 1'h0, 1'h0, 3'h7, 5'h00},
        '{3'h7, 3'h0, 5'h1F, 5'h00, 5'h00, 1'h0, 1'h0, 3'h7, 5'h1F},
        '{3'h7, 3'h0, 5'h1E, 5'h00, 5'h04, 1'h0, 1'h0, 3'h7, 5'h1F},
        '{3'h7, 3'h0, 5'h0A, 5'h00, 5'h03, 1'h0, 1'h0, 3'h7, 5'h0D},
        '{3'h1, 3'h7, 5'h05, 5'h00, 5'h00, 1'h1, 1'h0, 3'h7, 5'h05},
        '{3'h7, 3'h0, 5'h04, 5'h14, 5'h00, 1'h0, 1'h1, 3'h7, 5'h14}};

    always #20 pclk = ~pclk;

    rftxg_core u_rftxg_core (
        .pclk(pclk), .presetn(presetn), .clk_en(en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_end(ev[3]), .rx_emd_restart(emd), .field_on(ev[2]), .bit_grid_tick(ev[1]),
        .send_cmd(ev[0]), .tx_done(tx_done), .shaping_active(sh), .overshoot_active(ov),
        .mod_error_trim(trim), .gain_value(gain),
        .tx_start(tx_start), .tx_busy(tx_busy), .drive(drive)
    );

    rftxg_ant_model u_rftxg_ant_model (
        .pclk(pclk), .presetn(presetn), .slow(slow), .tx_start(tx_start), .tx_done(tx_done)
    );

    // event and start time stamps in clock cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (ev !== 4'h0) t_ev <= cyc;
        if (tx_start === 1'h1) begin
            t_start <= cyc;
            n_start <= n_start + 1;
        end
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s exp %h got %h", $time, what, exp, got);
        end
    endtask

    task automatic hang();
        chk(32'h0, 32'h1, "wait ran out");
        close_out();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (k == 20) hang();
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic pulse(input logic [3:0] m, input logic e);
        @(posedge pclk);
        ev <= m;
        emd <= e;
        @(posedge pclk);
        ev <= 4'h0;
        emd <= 1'h0;
    endtask

    task automatic wait_start(input int lim);
        int k;
        k = 0;
        while (n_start == s && k < lim) begin
            @(negedge pclk);
            k++;
        end
        if (n_start == s) hang();
        dt = t_start - t_ev;
    endtask

    task automatic idle();
        int k;
        k = 0;
        while (tx_busy !== 1'h0 && k < 100) begin
            @(negedge pclk);
            k++;
        end
        if (k == 100) hang();
        s = n_start;
    endtask

    task automatic state(input logic [3:0] e, input string what);
        apb(1'h0, rftxg_pkg::STATUS_OFS, 32'h0);
        chk({28'h0, e}, {28'h0, q[11:8]}, what);
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(negedge pclk);
        chk(32'h8, {16'h0, drive, pready, tx_busy, tx_start, pslverr}, "reset outputs");
        chk(32'h0, prdata, "reset data");
        foreach (rows[i]) begin
            apb(1'h1, rftxg_pkg::TX_CLOCK_CONTROL_OFS, {25'h0, rows[i].scm, 1'h0, rows[i].cm});
            apb(1'h1, rftxg_pkg::TX_CONTROL_OFS, {19'h0, rows[i].scar, 3'h0, rows[i].car});
            sh <= rows[i].sh;
            ov <= rows[i].ov;
            trim <= rows[i].trim;
            repeat (3) @(negedge pclk);
            chk({29'h0, rows[i].ecm}, {29'h0, drive.clock_mode}, "mode");
            chk({27'h0, rows[i].ecar}, {27'h0, drive.carrier_level}, "level");
        end
        s = n_start;
        apb(1'h1, rftxg_pkg::GUARD_CFG_OFS, 32'h2);
        pulse(4'h8, 1'h0);
        apb(1'h1, rftxg_pkg::SEQ_CTRL_OFS, 32'h1);
        wait_start(100);
        chk(32'h1, 32'(dt >= 48 && dt <= 54), "start at guard end");
        idle();
        pulse(4'h8, 1'h1);
        state(4'h1, "disturbance restart");
        apb(1'h1, rftxg_pkg::GUARD_CFG_OFS, 32'h402);
        pulse(4'h8, 1'h0);
        state(4'h1, "multi receive");
        apb(1'h1, rftxg_pkg::GUARD_CFG_OFS, 32'h002);
        pulse(4'h4, 1'h0);
        state(4'h1, "field up guard off");
        apb(1'h1, rftxg_pkg::GUARD_CFG_OFS, 32'h202);
        pulse(4'h4, 1'h0);
        state(4'h2, "field up guard on");
        repeat (60) @(negedge pclk);
        apb(1'h1, rftxg_pkg::GUARD_CFG_OFS, 32'h101);
        pulse(4'h8, 1'h0);
        repeat (40) @(negedge pclk);
        apb(1'h1, rftxg_pkg::SEQ_CTRL_OFS, 32'h1);
        repeat (10) @(negedge pclk);
        chk(32'(s), 32'(n_start), "no start off grid");
        pulse(4'h2, 1'h0);
        wait_start(5);
        chk(32'h1, 32'(dt <= 3), "start on grid");
        idle();
        apb(1'h1, rftxg_pkg::GUARD_CFG_OFS, 32'h0);
        slow <= 1'h1;
        repeat (10) @(negedge pclk);
        chk(32'(s), 32'(n_start), "no start untriggered");
        pulse(4'h1, 1'h0);
        wait_start(10);
        chk(32'h1, 32'(dt <= 3), "guard off start");
        idle();
        apb(1'h0, 8'h18, 32'h0);
        chk(32'h1, {31'h0, err}, "unmapped error");
        chk(32'h0, q, "unmapped data");
        apb(1'h1, rftxg_pkg::DRIVE_CFG_OFS, 32'h0080_0E02);
        repeat (4200) @(negedge pclk);
        chk(32'hE, {28'h0, drive.gear}, "gear top");
        @(posedge pclk);
        gain <= 8'hFF;
        dt = 0;
        while (drive.gear === 4'hE && dt < 300) begin
            @(negedge pclk);
            dt++;
        end
        chk(32'hD, {28'h0, drive.gear}, "gear step down");
        repeat (200) @(negedge pclk);
        chk(32'hD, {28'h0, drive.gear}, "sample interval");
        // clock enable low must freeze the gear across a sample point
        @(posedge pclk);
        en <= 1'h0;
        repeat (600) @(negedge pclk);
        chk(32'hD, {28'h0, drive.gear}, "frozen");
        @(posedge pclk);
        en <= 1'h1;
        repeat (3200) @(negedge pclk);
        chk(32'h2, {28'h0, drive.gear}, "gear bottom");
        // reset in mid-run clears configuration and gear
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, rftxg_pkg::DRIVE_CFG_OFS, 32'h0);
        chk(32'h0, q, "config after reset");
        chk(32'h0, {28'h0, drive.gear}, "gear after reset");
        close_out();
    end
endmodule
`default_nettype wire
